// File: core/char_disp_pkg.sv
// Purpose: Shared constants for the character display host port core
// Assumes: Single clock at 125 MHz, synchronous active-low reset
// Notes: Register map is reached through the parallel host pins only
package char_disp_pkg;
  // ****************
  // Reset values and counts
  // ****************
  localparam logic [6:0] AC_RESET = 7'h00;
  localparam logic [6:0] BASE_RESET = 7'h00;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE_MASK_2L = 7'h3f;
  localparam int OP_TIME_NS = 40;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [7:0] OP_CYCLES = 8'((OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SHIFT_STAGES = 100;
  localparam int CLK_DIV = 4;
  localparam int FIFO_DEPTH = 16;
  // Command field positions and command codes
  localparam int CMD_ADDR_BIT = 7;
  localparam int CMD_GLYPH_BIT = 6;
  localparam int CMD_SHIFT_BIT = 4;
  localparam int CMD_SHL_BIT = 2;
  localparam int CMD_INC_BIT = 1;
  localparam int CMD_LINES_BIT = 3;
  localparam logic [7:0] CMD_CLEAR = 8'h01;
  localparam logic [7:0] CMD_HOME = 8'h02;
  localparam logic [3:0] CMD_ENTRY_HI = 4'h0;
endpackage

// File: core/char_display_host_port.sv
// Purpose: Parallel host port, address logic and cascade shifter
// Assumes: Host pins synchronous to MCLK_I; strobe sampled each clock
// Notes: Glyph RAM modelled as 64 bytes; display refresh streams via FIFO
`timescale 1ns/10ps
`default_nettype none
module char_display_host_port #(
  parameter int STAGES = char_disp_pkg::SHIFT_STAGES
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic REG_SELECT_I,
  input wire logic READ_NOT_WRITE_I,
  input wire logic ENABLE_I,
  input wire logic [7:0] DB_I,
  output logic [7:0] DB_O,
  output logic DB_OE_O,
  input wire logic MASTER_SLAVE_SELECT_I,
  input wire logic SHIFT_DIRECTION_I,
  input wire logic SERIAL_DATA_I,
  output logic SERIAL_DATA_O,
  output logic SERIAL_DATA_OE_O,
  input wire logic SHIFT_CLOCK_I,
  output logic SHIFT_CLOCK_O,
  output logic SHIFT_CLOCK_OE_O,
  input wire logic LATCH_PULSE_I,
  output logic LATCH_PULSE_O,
  output logic LATCH_PULSE_OE_O,
  output logic BUSY_FLAG_O,
  output logic [6:0] DISPLAY_BASE_O
);
  // ****************
  // Host strobe and state
  // ****************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } op_state_e;
  op_state_e state;
  logic enable_d;
  logic strobe_fall;
  logic [7:0] instruction_register;
  logic [7:0] data_register;
  logic [6:0] address_counter;
  logic target_glyph;
  logic step_up;
  logic two_line;
  logic busy_flag;
  logic [7:0] op_count;
  logic [6:0] display_base;
  logic [7:0] char_ram [128];
  logic [7:0] glyph_ram [64];
  logic [6:0] next_ac;
  logic [6:0] next_base;
  logic cmd_take;
  logic data_take;
  logic [7:0] ram_word;
  assign strobe_fall = enable_d && !ENABLE_I;
  // Instructions dropped while busy, data too: host must poll first
  assign cmd_take = strobe_fall && !REG_SELECT_I && !READ_NOT_WRITE_I && !busy_flag;
  assign data_take = strobe_fall && REG_SELECT_I && !busy_flag;
  assign ram_word = target_glyph ? glyph_ram[address_counter[5:0]]
                                 : char_ram[address_counter];
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      enable_d <= 1'b0;
    end else begin
      enable_d <= ENABLE_I;
    end
  end
  always_comb begin
    next_ac = step_up ? address_counter + 7'h01 : address_counter - 7'h01;
    if (two_line) begin
      // Wrap stays inside the line that holds the base
      next_base = display_base[6] ? char_disp_pkg::LINE2_BASE : 7'h00;
      if (instruction_register[char_disp_pkg::CMD_SHL_BIT]) begin
        next_base = next_base | ((display_base + 7'h01) & char_disp_pkg::LINE_MASK_2L);
      end else begin
        next_base = next_base | ((display_base - 7'h01) & char_disp_pkg::LINE_MASK_2L);
      end
    end else begin
      next_base = instruction_register[char_disp_pkg::CMD_SHL_BIT] ?
        display_base + 7'h01 : display_base - 7'h01;
    end
  end
  // ****************
  // Operation sequencer
  // ****************
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      state <= ST_IDLE;
      op_count <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_take || data_take) begin
            state <= ST_BUSY;
            op_count <= char_disp_pkg::OP_CYCLES;
          end
        end
        ST_BUSY: begin
          if (op_count == 8'h01) begin
            state <= ST_DONE;
          end
          op_count <= op_count - 8'h01;
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      busy_flag <= 1'b0;
    end else begin
      busy_flag <= (cmd_take || data_take) || (state == ST_BUSY && op_count != 8'h01);
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      instruction_register <= 8'h00;
    end else if (cmd_take) begin
      instruction_register <= DB_I;
    end
  end
  // ****************
  // Address counter and modes
  // ****************
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      address_counter <= char_disp_pkg::AC_RESET;
      target_glyph <= 1'b0;
      step_up <= 1'b1;
      two_line <= 1'b0;
    end else if (cmd_take) begin
      if (DB_I[char_disp_pkg::CMD_ADDR_BIT]) begin
        address_counter <= DB_I[6:0];
        target_glyph <= 1'b0;
      end else if (DB_I[char_disp_pkg::CMD_GLYPH_BIT]) begin
        address_counter <= {1'b0, DB_I[5:0]};
        target_glyph <= 1'b1;
      end else if (DB_I[5]) begin
        two_line <= DB_I[char_disp_pkg::CMD_LINES_BIT];
      end else if (DB_I == char_disp_pkg::CMD_CLEAR || DB_I == char_disp_pkg::CMD_HOME) begin
        address_counter <= char_disp_pkg::AC_RESET;
        target_glyph <= 1'b0;
        if (DB_I == char_disp_pkg::CMD_CLEAR) begin
          step_up <= 1'b1;
        end
      end else if (DB_I[7:3] == 5'h00 && DB_I[2]) begin
        step_up <= DB_I[char_disp_pkg::CMD_INC_BIT];
      end
    end else if (data_take) begin
      address_counter <= target_glyph ? {1'b0, next_ac[5:0]} : next_ac;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      display_base <= char_disp_pkg::BASE_RESET;
    end else if (cmd_take && DB_I == char_disp_pkg::CMD_HOME) begin
      display_base <= char_disp_pkg::BASE_RESET;
    end else if (state == ST_DONE && instruction_register[7:3] == 5'h03
                 && instruction_register[char_disp_pkg::CMD_SHIFT_BIT - 1]) begin
      display_base <= next_base;
    end
  end
  // ****************
  // Data register and RAMs
  // ****************
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      data_register <= 8'h00;
    end else if (data_take) begin
      data_register <= READ_NOT_WRITE_I ? ram_word : DB_I;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (data_take && !READ_NOT_WRITE_I && !target_glyph) begin
      char_ram[address_counter] <= DB_I;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (data_take && !READ_NOT_WRITE_I && target_glyph) begin
      glyph_ram[address_counter[5:0]] <= DB_I;
    end
  end
  // Read bus: status or data register, never the instruction register
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      DB_O <= 8'h00;
      DB_OE_O <= 1'b0;
    end else begin
      DB_OE_O <= ENABLE_I && READ_NOT_WRITE_I;
      if (!REG_SELECT_I) begin
        DB_O <= {busy_flag, address_counter};
      end else if (data_take && READ_NOT_WRITE_I) begin
        DB_O <= ram_word;
      end else begin
        DB_O <= data_register;
      end
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      BUSY_FLAG_O <= 1'b0;
      DISPLAY_BASE_O <= char_disp_pkg::BASE_RESET;
    end else begin
      BUSY_FLAG_O <= busy_flag;
      DISPLAY_BASE_O <= display_base;
    end
  end
  // ****************
  // Cascade stream and shifter
  // ****************
  logic [6:0] scan_addr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic [7:0] out_byte;
  logic [2:0] bit_idx;
  logic byte_loaded;
  logic [1:0] div_count;
  logic sclk;
  logic sclk_d;
  logic sclk_fall;
  logic [STAGES-1:0] shift_reg;
  logic ser_in;
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      scan_addr <= 7'h00;
    end else if (fifo_in_ready && MASTER_SLAVE_SELECT_I) begin
      scan_addr <= scan_addr + 7'h01;
    end
  end
  char_fifo #(
    .WIDTH(8),
    .DEPTH(char_disp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .MCLK_I(MCLK_I),
    .RESETN_I(RESETN_I),
    .in_valid_i(MASTER_SLAVE_SELECT_I),
    .in_ready_o(fifo_in_ready),
    .in_data_i(char_ram[7'(scan_addr + display_base)]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!byte_loaded),
    .out_data_o(fifo_out_data)
  );
  // Master makes its shift clock by division, so no second domain
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      div_count <= 2'h0;
      sclk <= 1'b1;
    end else begin
      div_count <= div_count + 2'h1;
      if (div_count == 2'(char_disp_pkg::CLK_DIV - 1)) begin
        sclk <= !sclk;
      end
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= MASTER_SLAVE_SELECT_I ? sclk : SHIFT_CLOCK_I;
    end
  end
  assign sclk_fall = sclk_d && !(MASTER_SLAVE_SELECT_I ? sclk : SHIFT_CLOCK_I);
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      byte_loaded <= 1'b0;
      out_byte <= 8'h00;
      bit_idx <= 3'h0;
    end else if (!byte_loaded && fifo_out_valid) begin
      byte_loaded <= 1'b1;
      out_byte <= fifo_out_data;
      bit_idx <= 3'h0;
    end else if (byte_loaded && sclk_fall) begin
      bit_idx <= bit_idx + 3'h1;
      byte_loaded <= (bit_idx != 3'h7);
    end
  end
  assign ser_in = MASTER_SLAVE_SELECT_I ? out_byte[bit_idx] : SERIAL_DATA_I;
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      shift_reg <= '0;
    end else if (sclk_fall) begin
      if (SHIFT_DIRECTION_I) begin
        shift_reg <= {ser_in, shift_reg[STAGES-1:1]};
      end else begin
        shift_reg <= {shift_reg[STAGES-2:0], ser_in};
      end
    end
  end
  // Master drives cascade pins, slave releases them
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      SERIAL_DATA_O <= 1'b0;
      SHIFT_CLOCK_O <= 1'b1;
      LATCH_PULSE_O <= 1'b0;
      SERIAL_DATA_OE_O <= 1'b0;
      SHIFT_CLOCK_OE_O <= 1'b0;
      LATCH_PULSE_OE_O <= 1'b0;
    end else begin
      SERIAL_DATA_OE_O <= MASTER_SLAVE_SELECT_I;
      SHIFT_CLOCK_OE_O <= MASTER_SLAVE_SELECT_I;
      LATCH_PULSE_OE_O <= MASTER_SLAVE_SELECT_I;
      SERIAL_DATA_O <= SHIFT_DIRECTION_I ? shift_reg[0] : shift_reg[STAGES-1];
      SHIFT_CLOCK_O <= sclk;
      LATCH_PULSE_O <= MASTER_SLAVE_SELECT_I ? (byte_loaded && sclk_fall && bit_idx == 3'h7)
                                             : LATCH_PULSE_I;
    end
  end
  // ****************
  // Checks
  // ****************
  sequence cmd_seen;
    cmd_take;
  endsequence
  AST_BUSY_ON_CMD: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    cmd_seen |=> busy_flag ##1 BUSY_FLAG_O)
    else $error("busy flag not raised after instruction");
  AST_BUSY_CLEARS: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    cmd_take |-> ##[1:7] !busy_flag)
    else $error("busy flag stuck high");
  AST_NO_CMD_BUSY: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    busy_flag |-> !cmd_take)
    else $error("instruction taken while busy");
  AST_ADDR_LOAD: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    cmd_take && DB_I[7] |=> address_counter == $past(DB_I[6:0]) && !target_glyph)
    else $error("address counter not loaded");
  AST_AC_STEP: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    data_take && !target_glyph && step_up |=> address_counter == $past(address_counter) + 7'h01)
    else $error("address counter did not step");
  AST_STATUS_READ: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    !REG_SELECT_I |=> DB_O == {$past(busy_flag), $past(address_counter)})
    else $error("status byte wrong");
  AST_CASCADE_OE: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    ##1 SHIFT_CLOCK_OE_O == $past(MASTER_SLAVE_SELECT_I))
    else $error("cascade pin direction wrong");
  AST_SHIFT_HI: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    sclk_fall && SHIFT_DIRECTION_I |=> shift_reg[STAGES-1] == $past(ser_in))
    else $error("shift toward stage one wrong");
  AST_SHIFT_LO: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    sclk_fall && !SHIFT_DIRECTION_I |=> shift_reg[0] == $past(ser_in))
    else $error("shift toward stage hundred wrong");
endmodule
`default_nettype wire

// File: core/char_fifo.sv
// Purpose: Valid/ready FIFO in the display data path
// Assumes: Single clock, synchronous active-low reset
// Notes: Flip-flop storage, pointer with one extra wrap bit
`timescale 1ns/10ps
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      wr_ptr <= '0;
    end else if (in_valid_i && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (in_valid_i && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      rd_ptr <= '0;
    end else if (out_ready_i && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: verification/host_cpu_model.sv
// Purpose: Host processor model on the parallel register port
// Assumes: Port sampled on rising edges of mclk_i
// Notes: Data lines show the inverted last value once released
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic rs_o,
  output logic rw_o,
  output logic en_o,
  output logic [7:0] wdata_o
);
  initial begin
    rs_o = 1'b0;
    rw_o = 1'b1;
    en_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // ****************
  // Bus cycles
  // ****************
  // Fields held through the strobe fall and one clock beyond
  task automatic access(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
    rs_o = rs;
    rw_o = rw;
    wdata_o = d;
    en_o = 1'b1;
    cyc(1);
    en_o = 1'b0;
    cyc(2);
    q = rdata_i;
    wdata_o = ~d;
  endtask
  task automatic status(output logic [7:0] q);
    rs_o = 1'b0;
    rw_o = 1'b1;
    en_o = 1'b1;
    cyc(1);
    q = rdata_i;
    en_o = 1'b0;
    cyc(1);
  endtask
  // Bounded, so a stuck busy flag fails instead of hanging
  task automatic poll(output logic [7:0] q);
    int i;
    q = 8'h80;
    for (i = 0; i < 40 && q[7] !== 1'b0; i++) begin
      status(q);
    end
  endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Purpose: Self-checking bench for the display host port and its FIFO
// Assumes: Host model drives the port, bench model predicts every RAM, address and display base result
// Notes: Random values come from one fixed seed
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic rs, rw, en, db_oe, ms_sel, shl, sd_i, sck_i, lat_i, busy;
  logic sd_oe, sck_oe, lat_oe, sd_o, sck_o, lat_o;
  logic [7:0] wdata, rdata, q, e;
  logic [6:0] base, a, ac, mbase;
  logic gsel, inc, two_line;
  logic [7:0] cram [128];
  logic [7:0] gram [64];
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  always #4 mclk = ~mclk;
  host_cpu_model host (.mclk_i(mclk), .rdata_i(rdata), .rs_o(rs), .rw_o(rw),
    .en_o(en), .wdata_o(wdata));
  char_display_host_port dut (.MCLK_I(mclk), .RESETN_I(resetn), .REG_SELECT_I(rs),
    .READ_NOT_WRITE_I(rw), .ENABLE_I(en), .DB_I(wdata), .DB_O(rdata), .DB_OE_O(db_oe),
    .MASTER_SLAVE_SELECT_I(ms_sel), .SHIFT_DIRECTION_I(shl), .SERIAL_DATA_I(sd_i),
    .SERIAL_DATA_O(sd_o), .SERIAL_DATA_OE_O(sd_oe), .SHIFT_CLOCK_I(sck_i),
    .SHIFT_CLOCK_O(sck_o), .SHIFT_CLOCK_OE_O(sck_oe), .LATCH_PULSE_I(lat_i),
    .LATCH_PULSE_O(lat_o), .LATCH_PULSE_OE_O(lat_oe), .BUSY_FLAG_O(busy),
    .DISPLAY_BASE_O(base));
  // ****************
  // Reference model
  // ****************
  function automatic void m_step();
    if (gsel) ac = {1'b0, inc ? ac[5:0] + 6'h01 : ac[5:0] - 6'h01};
    else ac = inc ? ac + 7'h01 : ac - 7'h01;
  endfunction
  function automatic void m_instr(input logic [7:0] b);
    if (b[7]) begin
      ac = b[6:0];
      gsel = 1'b0;
    end else if (b[6]) begin
      ac = {1'b0, b[5:0]};
      gsel = 1'b1;
    end else if (b[5]) begin
      two_line = b[3];
    end else if (b[4]) begin
      if (b[3]) mbase = (b[2] ? mbase + 7'h01 : mbase - 7'h01) & (two_line ? 7'h3f : 7'h7f);
    end else if (b[2]) begin
      inc = b[1];
    end else if (b == 8'h02) begin
      ac = 7'h00;
      mbase = 7'h00;
    end else if (b == 8'h01) begin
      ac = 7'h00;
      inc = 1'b1;
    end
  endfunction
  task automatic instr(input logic [7:0] b);
    host.access(1'b0, 1'b0, b, q);
    m_instr(b);
    host.poll(q);
    `CHK("status", {1'b0, ac}, q)
  endtask
  task automatic wr(input logic [7:0] d);
    host.access(1'b1, 1'b0, d, q);
    if (gsel) gram[ac[5:0]] = d;
    else cram[ac] = d;
    m_step();
    host.poll(q);
    `CHK("address after write", {1'b0, ac}, q)
  endtask
  task automatic rd();
    host.access(1'b1, 1'b1, 8'h00, q);
    `CHK("read data", gsel ? gram[ac[5:0]] : cram[ac], q)
    m_step();
    host.poll(q);
    `CHK("address after read", {1'b0, ac}, q)
  endtask
  task automatic block(input logic [7:0] hdr);
    for (int i = 0; i < 4; i++) wr(8'($urandom));
    instr(hdr);
    for (int i = 0; i < 4; i++) rd();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    {ms_sel, shl, sd_i, lat_i} = 4'h0;
    sck_i = 1'b1;
    {ac, mbase, gsel, inc, two_line} = {7'h00, 7'h00, 3'b010};
    void'($urandom(32'h7211ebde));
    repeat (12) @(posedge mclk);
    #1 resetn = 1'b1;
    host.status(q);
    `CHK("status after reset", 8'h00, q)
    `CHK("base after reset", 7'h00, base)
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      a = (k < 2) ? (k[0] ? 7'h7e : 7'h01) : 7'($urandom);
      instr({6'h01, k[0], 1'b0});
      instr({1'b1, a});
      block({1'b1, a});
      instr({2'b01, a[5:0]});
      block({2'b01, a[5:0]});
      instr({1'b1, a});
      rd();
    end
    $display("test ram access done");
    host.access(1'b0, 1'b0, 8'h85, q);
    m_instr(8'h85);
    host.cyc(1);
    `CHK("busy flag", 1'b1, busy)
    host.access(1'b0, 1'b0, 8'h9a, q);
    host.poll(q);
    `CHK("ignored while busy", 8'h05, q)
    `CHK("busy flag idle", 1'b0, busy)
    $display("test busy done");
    for (int k = 0; k < 2; k++) begin
      instr({4'h2, k[0], 3'h0});
      instr(8'h02);
      for (int j = 0; j < 6; j++) begin
        instr((j < 2 || $urandom % 2) ? 8'h18 : 8'h1c);
        `CHK("display base", mbase, base)
      end
    end
    instr(8'h04);
    instr(8'h01);
    wr(8'h3c);
    $display("test shift and clear done");
    ms_sel = 1'b1;
    host.cyc(3);
    `CHK("master drives", 3'b111, {sd_oe, sck_oe, lat_oe})
    for (int j = 0; j < 64; j++) begin
      sck_i = j[1];
      sd_i = 1'($urandom);
      lat_i = (j == 63);
      shl = j[5];
      host.cyc(1);
      if (j == 31) ms_sel = 1'b0;
      if (j == 34) `CHK("slave receives", 3'b000, {sd_oe, sck_oe, lat_oe})
    end
    $display("test cascade done");
    // Master stream through the FIFO: clock toggles every 4 cycles, bytes latch
    ms_sel = 1'b1;
    n = 0;
    e = 8'h00;
    for (int j = 0; j < 160; j++) begin
      q = {7'h00, sck_o};
      host.cyc(1);
      if (sck_o !== q[0]) n++;
      if (lat_o === 1'b1) e++;
    end
    `CHK("shift clock edges", 40, n)
    `CHK("latch seen", 1'b1, e != 8'h00)
    `CHK("serial out known", 1'b0, $isunknown(sd_o))
    $display("test stream done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
